/* File: core/smc_pkg.sv */
// Operation
// - Permitted stop enters a depth, halts clocks
// - Unpermitted stop forces illegal-opcode reset instead
// - Select bits pick depth one, two, three
// - Depths one, two need detection unarmed
// - Depth one wakes on reset or low irq
// - Depth one forces detect, exit awaits rearm
// - Depth one wake restarts as power-on
// - Depth two latches pins until release write
// - Depth two wakes on reset, irq, periodic
// - Depth two wake resets all, pins latched
// - Depth two wake sets flag until release
// - Opened pins follow current port registers
// - Disabled peripheral pins follow port control
// - Depth three halts oscillator, keeps state
// - Depth three wakes reset, irq, keypad, periodic
// - Self-clocked tick wakes; rate zero disables
// - Debug permit keeps debug clocks, regulator
// - Debug permit turns depth one/two into three
// - Status memory commands err during stop
// - Background command wakes into debug mode
// - Armed detection keeps regulator, forces depth three
// - Depth one forces pins to reset state
package smc_pkg;

  // ----------------------------------------
  // Sizes and register map
  // ----------------------------------------
  localparam int PIN_W = 8;
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_RELEASE = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam int B_PERMIT = 0;
  localparam int B_PWRDN = 1;
  localparam int B_PARTDN = 2;
  localparam int B_LVON = 3;
  localparam int B_LVSLP = 4;
  localparam int B_DBG = 5;
  localparam int B_RATE = 8;
  localparam int RATE_W = 3;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] CTRL_MASK = 32'h0000_073f;
  localparam int B_RELEASE = 0;
  localparam int B_FLAG = 0;
  localparam int B_LATCH = 1;
  localparam int B_STATE = 4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int TICK_HZ = 1000;
  localparam int TICK_DIV_DFLT = CLK_HZ / TICK_HZ;
  localparam int DIV_W = 14;
  localparam int PER_W = 10;
  localparam logic [9:0] PER_BASE = 10'h004;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [3:0] {
    ST_RUN = 4'h1,
    ST_STOP1 = 4'h2,
    ST_STOP2 = 4'h4,
    ST_STOP3 = 4'h8
  } smc_state_t;

  typedef enum logic [1:0] {
    VEC_RESET = 2'h0,
    VEC_IRQ = 2'h1,
    VEC_KEYPAD = 2'h2,
    VEC_PERIODIC = 2'h3
  } smc_vec_t;

  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } smc_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } smc_axi_rsp_t;

endpackage : smc_pkg

/* File: core/smc_stop_ctrl.sv */
// The register offsets and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
module smc_stop_ctrl
  import smc_pkg::*;
#(
  parameter int TICK_DIV = TICK_DIV_DFLT
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire smc_axi_req_t axi_req,
  output smc_axi_rsp_t axi_rsp,
  // CPU
  input wire logic stop_exec,
  // Wake sources
  input wire logic reset_pin_n,
  input wire logic irq_pin_n,
  input wire logic keypad_irq,
  input wire logic lowv_rearm_ok,
  // Debug port
  input wire logic dbg_background_cmd,
  input wire logic dbg_mem_status_cmd,
  // Port and peripheral drive
  input wire logic [PIN_W-1:0] port_out,
  input wire logic [PIN_W-1:0] port_oe,
  input wire logic [PIN_W-1:0] periph_en,
  input wire logic [PIN_W-1:0] periph_out,
  input wire logic [PIN_W-1:0] periph_oe,
  // Pins
  output logic [PIN_W-1:0] pin_out,
  output logic [PIN_W-1:0] pin_oe_n,
  // Power and clock control
  output logic clocks_halt,
  output logic osc_halt,
  output logic debug_clk_run,
  output logic regulator_standby,
  output logic lowv_force,
  output logic tick_src_on,
  // Wake results
  output logic sys_reset_req,
  output logic illegal_reset,
  output logic wake_irq,
  output smc_vec_t vector_sel,
  output logic debug_enter,
  output logic dbg_status_err,
  output logic dbg_mem_grant
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  smc_state_t state;
  logic [31:0] ctrl;
  logic flag;
  logic latched;
  logic dbg_s;
  logic lowv_s;
  logic [RATE_W-1:0] rate_s;
  logic [DIV_W-1:0] div_cnt;
  logic [PER_W-1:0] per_cnt;
  logic [PER_W-1:0] per_limit;
  logic tick;
  logic per_hit;
  logic wake_pin;
  logic lowv_armed;
  logic [PIN_W-1:0] next_pin_out;
  logic [PIN_W-1:0] next_pin_oe_n;

  logic awready;
  logic wready;
  logic bvalid;
  logic [1:0] bresp;
  logic arready;
  logic rvalid;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [31:0] strb_mask;
  logic wr_go;
  logic rel_wr;

  // Bus answer straight from its flops
  assign axi_rsp = '{awready, wready, bvalid, bresp,
                     arready, rvalid, rdata, rresp};

  // ----------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------
  // Address and data are taken independently, in either order or in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (awready && axi_req.awvalid) begin
      awready <= 1'b0;
      aw_held <= 1'b1;
      aw_addr <= axi_req.awaddr;
    end else if (wr_go) begin
      aw_held <= 1'b0;
    end else if (!aw_held && !bvalid && axi_req.awvalid) begin
      awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready <= 1'b0;
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else if (wready && axi_req.wvalid) begin
      wready <= 1'b0;
      w_held <= 1'b1;
      w_data <= axi_req.wdata;
      w_strb <= axi_req.wstrb;
    end else if (wr_go) begin
      w_held <= 1'b0;
    end else if (!w_held && !bvalid && axi_req.wvalid) begin
      wready <= 1'b1;
    end
  end

  assign wr_go = aw_held && w_held && !bvalid;
  assign rel_wr = wr_go && (aw_addr == OFS_RELEASE)
                  && w_strb[0] && w_data[B_RELEASE];

  // Byte enables to a bit mask
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      strb_mask[8*b +: 8] = {8{w_strb[b]}};
    end
  end

  // Response once both halves are in
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid <= 1'b1;
      if (aw_addr == OFS_CTRL || aw_addr == OFS_RELEASE) begin
        bresp <= RESP_OKAY;
      end else begin
        bresp <= RESP_SLVERR;
      end
    end else if (bvalid && axi_req.bready) begin
      bvalid <= 1'b0;
    end
  end

  // Control word; a power-on style wake returns it to defaults
  always_ff @(posedge aclk) begin
    if (!aresetn || sys_reset_req) begin
      ctrl <= CTRL_RST;
    end else if (wr_go && aw_addr == OFS_CTRL) begin
      ctrl <= (ctrl & ~strb_mask) | (w_data & strb_mask & CTRL_MASK);
    end
  end

  // ----------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end else if (arready && axi_req.arvalid) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rresp <= RESP_OKAY;
      rdata <= '0;
      unique case (axi_req.araddr)
        OFS_CTRL: rdata <= ctrl;
        OFS_RELEASE: rdata <= '0;
        OFS_STATUS: begin
          rdata[B_FLAG] <= flag;
          rdata[B_LATCH] <= latched;
          rdata[B_STATE +: 4] <= state;
        end
        default: rresp <= RESP_SLVERR;
      endcase
    end else if (rvalid && axi_req.rready) begin
      rvalid <= 1'b0;
    end else if (!rvalid && axi_req.arvalid) begin
      arready <= 1'b1;
    end
  end

  // ----------------------------------------
  // Stop sequencer
  // ----------------------------------------
  // Reset and irq pins are both sampled active low; there is no polarity setting
  assign wake_pin = !reset_pin_n || !irq_pin_n;
  assign lowv_armed = ctrl[B_LVON] && ctrl[B_LVSLP];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_RUN;
      dbg_s <= 1'b0;
      lowv_s <= 1'b0;
      rate_s <= '0;
      sys_reset_req <= 1'b0;
      illegal_reset <= 1'b0;
      wake_irq <= 1'b0;
      debug_enter <= 1'b0;
      vector_sel <= VEC_RESET;
    end else begin
      sys_reset_req <= 1'b0;
      illegal_reset <= 1'b0;
      wake_irq <= 1'b0;
      debug_enter <= 1'b0;
      unique case (state)
        ST_RUN: begin
          if (stop_exec && !ctrl[B_PERMIT]) begin
            illegal_reset <= 1'b1;
            vector_sel <= VEC_RESET;
          end else if (stop_exec) begin
            // Settings frozen here so later writes cannot move the depth
            dbg_s <= ctrl[B_DBG];
            lowv_s <= lowv_armed;
            rate_s <= ctrl[B_RATE +: RATE_W];
            if (!ctrl[B_PWRDN] || ctrl[B_DBG] || lowv_armed) begin
              state <= ST_STOP3;
            end else if (ctrl[B_PARTDN]) begin
              state <= ST_STOP2;
            end else begin
              state <= ST_STOP1;
            end
          end
        end
        ST_STOP1: begin
          // Held until the supply is back above the rearm point
          if (wake_pin && lowv_rearm_ok) begin
            state <= ST_RUN;
            sys_reset_req <= 1'b1;
            vector_sel <= VEC_RESET;
          end
        end
        ST_STOP2: begin
          if (wake_pin || per_hit) begin
            state <= ST_RUN;
            sys_reset_req <= 1'b1;
            vector_sel <= VEC_RESET;
          end
        end
        ST_STOP3: begin
          if (!reset_pin_n) begin
            state <= ST_RUN;
            sys_reset_req <= 1'b1;
            vector_sel <= VEC_RESET;
          end else if (dbg_s && dbg_background_cmd) begin
            state <= ST_RUN;
            debug_enter <= 1'b1;
          end else if (!irq_pin_n) begin
            state <= ST_RUN;
            wake_irq <= 1'b1;
            vector_sel <= VEC_IRQ;
          end else if (keypad_irq) begin
            state <= ST_RUN;
            wake_irq <= 1'b1;
            vector_sel <= VEC_KEYPAD;
          end else if (per_hit) begin
            state <= ST_RUN;
            wake_irq <= 1'b1;
            vector_sel <= VEC_PERIODIC;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // Clock and regulator controls
  // ----------------------------------------
  // One cycle behind the state, which is harmless at these depths
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clocks_halt <= 1'b0;
      osc_halt <= 1'b0;
      debug_clk_run <= 1'b0;
      regulator_standby <= 1'b0;
      lowv_force <= 1'b0;
    end else begin
      clocks_halt <= (state != ST_RUN);
      osc_halt <= (state != ST_RUN) && !dbg_s;
      debug_clk_run <= (state != ST_RUN) && dbg_s;
      regulator_standby <= (state != ST_RUN) && !dbg_s && !lowv_s;
      lowv_force <= (state == ST_STOP1);
    end
  end

  // ----------------------------------------
  // Periodic wake timer
  // ----------------------------------------
  // Internal tick is not available in depth three with debug on
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_src_on <= 1'b0;
    end else begin
      tick_src_on <= (rate_s != '0) &&
                     ((state == ST_STOP2) || (state == ST_STOP3 && !dbg_s));
    end
  end

  assign tick = tick_src_on && (div_cnt == DIV_W'(TICK_DIV - 1));
  assign per_limit = PER_BASE << rate_s;
  assign per_hit = tick && (per_cnt == per_limit - 10'h001);

  always_ff @(posedge aclk) begin
    if (!aresetn || !tick_src_on) begin
      div_cnt <= '0;
      per_cnt <= '0;
    end else if (tick) begin
      div_cnt <= '0;
      per_cnt <= per_hit ? '0 : per_cnt + 10'h001;
    end else begin
      div_cnt <= div_cnt + 14'h0001;
    end
  end

  // ----------------------------------------
  // Pin latch and wake flag
  // ----------------------------------------
  // Set beats the release write in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      latched <= 1'b0;
      flag <= 1'b0;
    end else begin
      if (state == ST_STOP2) begin
        latched <= 1'b1;
      end else if (rel_wr) begin
        latched <= 1'b0;
      end
      if (state == ST_STOP2 && (wake_pin || per_hit)) begin
        flag <= 1'b1;
      end else if (rel_wr) begin
        flag <= 1'b0;
      end
    end
  end

  // Per-pin source select
  generate
    for (genvar i = 0; i < PIN_W; i++) begin : g_pin
      assign next_pin_out[i] = periph_en[i] ? periph_out[i] : port_out[i];
      assign next_pin_oe_n[i] = !(periph_en[i] ? periph_oe[i] : port_oe[i]);
    end
  endgenerate

  // Depth three keeps driving from the retained port logic
  always_ff @(posedge aclk) begin
    if (!aresetn || state == ST_STOP1) begin
      pin_out <= '0;
      pin_oe_n <= '1;
    end else if (!latched && state != ST_STOP2) begin
      pin_out <= next_pin_out;
      pin_oe_n <= next_pin_oe_n;
    end
  end

  // ----------------------------------------
  // Debug command screening
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dbg_status_err <= 1'b0;
      dbg_mem_grant <= 1'b0;
    end else begin
      dbg_status_err <= dbg_mem_status_cmd && (state != ST_RUN);
      dbg_mem_grant <= dbg_mem_status_cmd && (state == ST_RUN);
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_illegal;
    @(posedge aclk) disable iff (!aresetn)
    state == ST_RUN && stop_exec && !ctrl[B_PERMIT]
      |=> illegal_reset && state == ST_RUN;
  endproperty
  a_illegal: assert property (p_illegal) else $error("no illegal reset");

  property p_enter;
    @(posedge aclk) disable iff (!aresetn)
    state == ST_RUN && stop_exec && ctrl[B_PERMIT]
      |=> state != ST_RUN ##1 clocks_halt;
  endproperty
  a_enter: assert property (p_enter) else $error("stop not entered");

  property p_depth3;
    @(posedge aclk) disable iff (!aresetn)
    state == ST_RUN && stop_exec && ctrl[B_PERMIT] && !ctrl[B_PWRDN]
      |=> state == ST_STOP3;
  endproperty
  a_depth3: assert property (p_depth3) else $error("depth three missed");

  property p_depth1;
    @(posedge aclk) disable iff (!aresetn)
    state == ST_RUN && stop_exec && ctrl[B_PERMIT] && ctrl[B_PWRDN]
      && !ctrl[B_PARTDN] && !ctrl[B_DBG] && !lowv_armed
      |=> state == ST_STOP1 ##1 lowv_force;
  endproperty
  a_depth1: assert property (p_depth1) else $error("depth one missed");

  property p_dbg3;
    @(posedge aclk) disable iff (!aresetn)
    state == ST_RUN && stop_exec && ctrl[B_PERMIT] && ctrl[B_DBG]
      |=> state == ST_STOP3 ##1 debug_clk_run && !regulator_standby;
  endproperty
  a_dbg3: assert property (p_dbg3) else $error("debug depth wrong");

  property p_lowv3;
    @(posedge aclk) disable iff (!aresetn)
    state == ST_RUN && stop_exec && ctrl[B_PERMIT] && lowv_armed
      |=> state == ST_STOP3 ##1 !regulator_standby;
  endproperty
  a_lowv3: assert property (p_lowv3) else $error("armed detect ignored");

  property p_s1_hold;
    @(posedge aclk) disable iff (!aresetn)
    state == ST_STOP1 && !lowv_rearm_ok |=> state == ST_STOP1;
  endproperty
  a_s1_hold: assert property (p_s1_hold) else $error("early depth one exit");

  property p_s1_pins;
    @(posedge aclk) disable iff (!aresetn)
    state == ST_STOP1 |=> pin_oe_n == '1 && pin_out == '0;
  endproperty
  a_s1_pins: assert property (p_s1_pins) else $error("pins not reset");

  property p_latch;
    @(posedge aclk) disable iff (!aresetn)
    latched && $past(latched) |-> $stable(pin_out) && $stable(pin_oe_n);
  endproperty
  a_latch: assert property (p_latch) else $error("latched pin moved");

  property p_flag;
    @(posedge aclk) disable iff (!aresetn)
    state == ST_STOP2 && (wake_pin || per_hit)
      |=> flag && sys_reset_req && state == ST_RUN;
  endproperty
  a_flag: assert property (p_flag) else $error("wake flag not set");

  property p_dbg_err;
    @(posedge aclk) disable iff (!aresetn)
    state != ST_RUN && dbg_mem_status_cmd |=> dbg_status_err && !dbg_mem_grant;
  endproperty
  a_dbg_err: assert property (p_dbg_err) else $error("stop access allowed");

  property p_rti_off;
    @(posedge aclk) disable iff (!aresetn)
    rate_s == '0 |-> !tick_src_on && !per_hit;
  endproperty
  a_rti_off: assert property (p_rti_off) else $error("rate zero ran tick");

endmodule : smc_stop_ctrl

/* File: test/smc_stop_ctrl_tb.sv */
`timescale 1ns/1ps
module smc_stop_ctrl_tb;
  import smc_pkg::*;

  // ------------------------------------------
  // Signals, expectation queues, counters
  // ------------------------------------------
  localparam logic [7:0] EV_SYS = 8'h04;
  localparam logic [7:0] EV_ILL = 8'h08;
  localparam logic [7:0] EV_IRQ = 8'h10;
  localparam logic [7:0] EV_DBG = 8'h20;
  localparam logic [7:0] EV_ERR = 8'h40;
  localparam logic [7:0] EV_GNT = 8'h80;
  logic aclk, aresetn, stop_exec, reset_pin_n, irq_pin_n, keypad_irq, lowv_rearm_ok;
  logic dbg_bg, dbg_ms, clocks_halt, osc_halt, debug_clk_run, regulator_standby;
  logic lowv_force, tick_src_on, sys_reset_req, illegal_reset, wake_irq, debug_enter;
  logic dbg_status_err, dbg_mem_grant;
  logic [PIN_W-1:0] port_out, port_oe, periph_en, periph_out, periph_oe, pin_out, pin_oe_n;
  logic [PIN_W-1:0] p1, p2;
  logic [31:0] ctl;
  logic [5:0] pwr;
  logic [7:0] ev_seen, exp_e;
  logic [33:0] exp_r;
  smc_vec_t vector_sel;
  smc_axi_req_t req;
  smc_axi_rsp_t rsp;
  logic [33:0] rsp_q[$];
  logic [7:0] ev_q[$];
  int fails, checks_done, cycles, k;

  smc_stop_ctrl #(.TICK_DIV(4)) i_dut (
    .aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp), .stop_exec(stop_exec),
    .reset_pin_n(reset_pin_n), .irq_pin_n(irq_pin_n), .keypad_irq(keypad_irq),
    .lowv_rearm_ok(lowv_rearm_ok), .dbg_background_cmd(dbg_bg), .dbg_mem_status_cmd(dbg_ms),
    .port_out(port_out), .port_oe(port_oe), .periph_en(periph_en), .periph_out(periph_out),
    .periph_oe(periph_oe), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .clocks_halt(clocks_halt), .osc_halt(osc_halt), .debug_clk_run(debug_clk_run),
    .regulator_standby(regulator_standby), .lowv_force(lowv_force), .tick_src_on(tick_src_on),
    .sys_reset_req(sys_reset_req), .illegal_reset(illegal_reset), .wake_irq(wake_irq),
    .vector_sel(vector_sel), .debug_enter(debug_enter), .dbg_status_err(dbg_status_err),
    .dbg_mem_grant(dbg_mem_grant)
  );

  // Levels and pulses packed so one compare covers a whole group
  assign pwr = {clocks_halt, osc_halt, debug_clk_run, regulator_standby,
    lowv_force, tick_src_on};
  assign ev_seen = {dbg_mem_grant, dbg_status_err, debug_enter, wake_irq, illegal_reset,
    sys_reset_req, (wake_irq | sys_reset_req) ? 2'(vector_sel) : 2'h0};

  // ------------------------------------------
  // Shared tasks
  // ------------------------------------------
  task automatic check(input string what, input logic [33:0] seen, input logic [33:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : summarize

  // Address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp);
    logic done;
    done = 1'b0;
    rsp_q.push_back({resp, 32'h0});
    @(posedge aclk);
    req.awaddr <= a;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
      if (rsp.bvalid) begin
        req.bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, input logic [1:0] resp, input logic [31:0] d);
    logic done;
    done = 1'b0;
    rsp_q.push_back({resp, d});
    @(posedge aclk);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
      if (rsp.rvalid) begin
        req.rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask : axi_rd

  // Settings go in first; the stop pulse is the sampling moment
  task automatic enter_stop(input logic [31:0] c, input logic [31:0] st);
    axi_wr(OFS_CTRL, c, RESP_OKAY);
    @(posedge aclk);
    stop_exec <= 1'b1;
    @(posedge aclk);
    stop_exec <= 1'b0;
    repeat (3) @(posedge aclk);
    axi_rd(OFS_STATUS, RESP_OKAY, st);
  endtask : enter_stop

  task automatic drain();
    while (ev_q.size() != 0) @(posedge aclk);
    @(posedge aclk);
  endtask : drain

  // ------------------------------------------
  // Clock, watchdog and result monitors
  // ------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  // Hang guard, far beyond the few thousand cycles the tests need
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      summarize();
    end
  end

  // Bus answers compared against the oldest noted expectation
  always @(posedge aclk) begin
    if ((rsp.bvalid && req.bready) || (rsp.rvalid && req.rready)) begin
      if (rsp_q.size() != 0) exp_r = rsp_q.pop_front();
      else exp_r = 'x;
      if (rsp.bvalid) check("write response", {rsp.bresp, 32'h0}, exp_r);
      else check("read data", {rsp.rresp, rsp.rdata}, exp_r);
    end
  end

  // Any wake or debug pulse must have been announced; stray ones fail
  always @(posedge aclk) begin
    if (aresetn && ev_seen[7:2] != 6'h0) begin
      if (ev_q.size() != 0) exp_e = ev_q.pop_front();
      else exp_e = 'x;
      check("event", 34'(ev_seen), 34'(exp_e));
    end
  end

  // ------------------------------------------
  // Main sequence
  // ------------------------------------------
  initial begin
    aresetn = 1'b0;
    stop_exec = 1'b0;
    reset_pin_n = 1'b1;
    irq_pin_n = 1'b1;
    keypad_irq = 1'b0;
    lowv_rearm_ok = 1'b0;
    dbg_bg = 1'b0;
    dbg_ms = 1'b0;
    port_out = 8'h00;
    port_oe = 8'hff;
    periph_en = 8'h00;
    periph_out = 8'h00;
    periph_oe = 8'h00;
    req = '0;
    void'($urandom(59));
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    // Register map, masking, reserved offset
    axi_rd(OFS_CTRL, RESP_OKAY, 32'h0);
    axi_rd(OFS_STATUS, RESP_OKAY, 32'h10);
    axi_wr(OFS_CTRL, 32'hffff_ffff, RESP_OKAY);
    axi_rd(OFS_CTRL, RESP_OKAY, CTRL_MASK);
    axi_rd(OFS_RELEASE, RESP_OKAY, 32'h0);
    axi_wr(8'h0c, 32'h1, RESP_SLVERR);
    axi_rd(8'h0c, RESP_SLVERR, 32'h0);
    $display("test registers done");
    // Stop without permission
    ev_q.push_back(EV_ILL);
    enter_stop(32'h0000_0002, 32'h10);
    drain();
    $display("test refused stop done");
    // Depth two, detection on but not armed for stop, random periodic rate
    p1 = 8'($urandom);
    p2 = 8'($urandom);
    port_out <= p1;
    ctl = 32'h0000_000f | (32'($urandom_range(7, 1)) << B_RATE);
    enter_stop(ctl, 32'h42);
    ev_q.push_back(EV_SYS);
    check("power", 34'(pwr), 34'(6'b110101));
    port_out <= ~p1;
    repeat (2) @(posedge aclk);
    check("held pins", 34'(pin_out), 34'(p1));
    drain();
    axi_rd(OFS_STATUS, RESP_OKAY, 32'h13);
    axi_rd(OFS_CTRL, RESP_OKAY, 32'h0);
    check("latched pins", 34'(pin_out), 34'(p1));
    port_out <= p2;
    periph_out <= ~p2;
    axi_wr(OFS_RELEASE, 32'h1, RESP_OKAY);
    repeat (2) @(posedge aclk);
    check("opened pins", 34'(pin_out), 34'(p2));
    axi_rd(OFS_STATUS, RESP_OKAY, 32'h10);
    $display("test depth two done");
    // Depth one: periodic and keypad ignored, exit waits for rearm
    enter_stop(32'h0000_0103, 32'h20);
    check("power", 34'(pwr), 34'(6'b110110));
    check("pin enables", 34'(pin_oe_n), 34'(8'hff));
    irq_pin_n <= 1'b0;
    keypad_irq <= 1'b1;
    repeat (60) @(posedge aclk);
    axi_rd(OFS_STATUS, RESP_OKAY, 32'h20);
    ev_q.push_back(EV_SYS);
    lowv_rearm_ok <= 1'b1;
    drain();
    irq_pin_n <= 1'b1;
    keypad_irq <= 1'b0;
    axi_rd(OFS_CTRL, RESP_OKAY, 32'h0);
    axi_rd(OFS_STATUS, RESP_OKAY, 32'h10);
    $display("test depth one done");
    // Depth three, one wake source at a time
    for (k = 0; k < 4; k++) begin
      ctl = (k == 3) ? 32'h0000_0105 : 32'h0000_0005;
      enter_stop(ctl, 32'h80);
      check("power", 34'(pwr), 34'({5'b11010, k == 3}));
      if (k == 0) begin
        repeat (100) @(posedge aclk);
        axi_rd(OFS_STATUS, RESP_OKAY, 32'h80);
      end
      ev_q.push_back((k == 2) ? EV_SYS : (EV_IRQ | 8'((k == 3) ? 3 : k + 1)));
      @(posedge aclk);
      irq_pin_n <= (k != 0);
      keypad_irq <= (k == 1);
      reset_pin_n <= (k != 2);
      drain();
      irq_pin_n <= 1'b1;
      keypad_irq <= 1'b0;
      reset_pin_n <= 1'b1;
      axi_rd(OFS_CTRL, RESP_OKAY, (k == 2) ? 32'h0 : ctl);
    end
    $display("test depth three done");
    // Debug permit turns a depth one request into depth three
    enter_stop(32'h0000_0023, 32'h80);
    check("power", 34'(pwr), 34'(6'b101000));
    ev_q.push_back(EV_ERR);
    dbg_ms <= 1'b1;
    @(posedge aclk);
    dbg_ms <= 1'b0;
    drain();
    ev_q.push_back(EV_DBG);
    dbg_bg <= 1'b1;
    @(posedge aclk);
    dbg_bg <= 1'b0;
    drain();
    axi_rd(OFS_STATUS, RESP_OKAY, 32'h10);
    ev_q.push_back(EV_GNT);
    dbg_ms <= 1'b1;
    @(posedge aclk);
    dbg_ms <= 1'b0;
    drain();
    $display("test debug permit done");
    // Detection armed for stop: depth two request becomes depth three
    enter_stop(32'h0000_001f, 32'h80);
    check("power", 34'(pwr), 34'(6'b110000));
    ev_q.push_back(EV_IRQ | 8'h01);
    irq_pin_n <= 1'b0;
    drain();
    irq_pin_n <= 1'b1;
    $display("test armed detection done");
    summarize();
  end

endmodule : smc_stop_ctrl_tb
